// ==== ide_encoder.sv ====
// Receive and serial-port event encoder producing 32-bit interrupt descriptors.
// Assumes event inputs from core_clk logic, except oofPin which is asynchronous.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Pad idle-to-abort change posts code 5
// - Pad abort-to-idle change posts code 6
// - Return to in-frame posts code 7
// - SS7 monitor increment posts code 8
// - SS7 monitor decrement posts code 9
// - SS7 duplicate message dropped, posts code 10
// - Error field zero means no error
// - Internal buffer loss reports error code 1
// - Event field bits 23:20, zero none
// - Group low bits 30:29, high bit 14
// - One event or one error per descriptor, never both
module ide_encoder
	import ide_pkg::*;
#(
	parameter int SIG_W = 32,
	parameter int CNT_W = 8
)
(
	input  wire logic             core_clk,
	input  wire logic             reset,
	input  wire logic             padValid,
	input  wire logic [2:0]       padGrp,
	input  wire logic [4:0]       padCh,
	input  wire logic [7:0]       padOctet,
	input  wire logic             oofPin,
	input  wire logic [2:0]       portGrp,
	input  wire logic [CNT_W-1:0] monCount,
	input  wire logic [2:0]       monGrp,
	input  wire logic [4:0]       monCh,
	input  wire logic             msgDone,
	input  wire logic [2:0]       msgGrp,
	input  wire logic [4:0]       msgCh,
	input  wire logic [SIG_W-1:0] msgSig,
	output logic                  msgKeep,
	output logic                  msgDrop,
	input  wire logic             bufErr,
	input  wire logic             bufErrDir,
	input  wire logic [2:0]       bufErrGrp,
	input  wire logic [4:0]       bufErrCh,
	output logic                  descValid,
	output logic      [31:0]      descWord,
	input  wire logic             descReady,
	input  wire logic [7:0]       regAddr,
	input  wire logic [31:0]      regWdata,
	input  wire logic             regWr,
	input  wire logic             regRd,
	output logic      [31:0]      regRdata,
	output logic                  irq
);

	generate
		if (SIG_W < 1 || SIG_W > 32 || CNT_W < 1 || CNT_W > 16)
		begin : g_bad_param
			$error("ide_encoder: SIG_W must be 1..32 and CNT_W 1..16");
		end
	endgenerate

	typedef enum logic [1:0]
	{
		IDE_FLT_IDLE = 2'b01,
		IDE_FLT_CMP  = 2'b10
	} ide_flt_t;

	typedef struct packed
	{
		logic       pend;
		logic       dir;
		logic [2:0] grp;
		logic [4:0] ch;
	} ide_slot_t;

	typedef struct packed
	{
		logic [1:0]                oofSync;
		logic                      oofPrev;
		logic                      ss7Mode;
		logic [NUM_SRC-1:0]        evMask;
		logic [7:0]                status;
		logic [7:0]                irqEn;
		logic [31:0]               rdData;
		logic [255:0]              padAbort;
		logic [CNT_W-1:0]          monPrev;
		logic                      monSeen;
		logic [255:0]              sigValid;
		ide_flt_t                  flt;
		logic [7:0]                fltKey;
		logic [SIG_W-1:0]          fltSig;
		logic                      msgKeep;
		logic                      msgDrop;
		ide_slot_t [NUM_SRC-1:0]   slots;
		logic                      descValid;
		logic [31:0]               descWord;
	} ide_state_t;

	ide_state_t       s;
	ide_state_t       n;
	logic             memRdEn;
	logic [7:0]       memRdAddr;
	logic [SIG_W-1:0] memRdData;
	logic             memWrEn;

	// Only codes of this table can leave the block
	function automatic logic [3:0] srcEvent(input int idx);
		case (idx)
			SRC_PAD_ABORT: srcEvent = EV_PAD_ABORT;
			SRC_PAD_IDLE:  srcEvent = EV_PAD_IDLE;
			SRC_FRAME_REC: srcEvent = EV_FRAME_REC;
			SRC_MON_INC:   srcEvent = EV_MON_INC;
			SRC_MON_DEC:   srcEvent = EV_MON_DEC;
			SRC_DUP_FILT:  srcEvent = EV_DUP_FILT;
			default:       srcEvent = EV_NONE;
		endcase
	endfunction

	function automatic logic [31:0] buildDesc(input ide_slot_t sl, input int idx);
		logic [31:0] w;
		w = '0;
		w[DESC_DIR_BIT] = sl.dir;
		w[DESC_GRP_LO_MSB:DESC_GRP_LO_LSB] = sl.grp[1:0];
		w[DESC_GRP_HI_BIT] = sl.grp[2];
		w[DESC_CH_MSB:DESC_CH_LSB] = sl.ch;
		// A slot maps to a single event or a single error, never more
		w[DESC_EV_MSB:DESC_EV_LSB] = srcEvent(idx);
		w[DESC_ERR_MSB:DESC_ERR_LSB] = (idx == SRC_BUF_ERR) ? ERR_BUFFER : ERR_NONE;
		buildDesc = w;
	endfunction

	ide_slot_t [NUM_SRC-1:0] evInfo;
	logic      [NUM_SRC-1:0] evHit;
	logic      [7:0]         padKey;
	logic                    taken;
	logic                    lost;
	logic                    dup;
	logic      [7:0]         w1c;

	always_comb
	begin
		n = s;
		evHit = '0;
		evInfo = '0;
		taken = 1'b0;
		lost = 1'b0;
		dup = 1'b0;
		w1c = '0;
		memRdEn = 1'b0;
		memRdAddr = {msgGrp, msgCh};
		memWrEn = 1'b0;
		padKey = {padGrp, padCh};
		n.msgKeep = 1'b0;
		n.msgDrop = 1'b0;
		n.rdData = '0;

		// Out-of-frame pin: two flops, then a third for the edge
		n.oofSync = {s.oofSync[0], oofPin};
		n.oofPrev = s.oofSync[1];
		if (s.oofPrev && !s.oofSync[1])
		begin
			evHit[SRC_FRAME_REC] = 1'b1;
			evInfo[SRC_FRAME_REC].grp = portGrp;
		end

		// Pad-fill tracking; other octets leave the state alone
		if (padValid)
		begin
			if (padOctet == PAD_ABORT_OCT && !s.padAbort[padKey])
			begin
				n.padAbort[padKey] = 1'b1;
				evHit[SRC_PAD_ABORT] = 1'b1;
				evInfo[SRC_PAD_ABORT].grp = padGrp;
				evInfo[SRC_PAD_ABORT].ch = padCh;
			end
			else if (padOctet == PAD_IDLE_OCT && s.padAbort[padKey])
			begin
				n.padAbort[padKey] = 1'b0;
				evHit[SRC_PAD_IDLE] = 1'b1;
				evInfo[SRC_PAD_IDLE].grp = padGrp;
				evInfo[SRC_PAD_IDLE].ch = padCh;
			end
		end

		// Monitor counter steps; first sample after reset only primes
		n.monPrev = monCount;
		n.monSeen = 1'b1;
		if (s.monSeen && s.ss7Mode && monCount != s.monPrev)
		begin
			if (monCount > s.monPrev)
			begin
				evHit[SRC_MON_INC] = 1'b1;
			end
			else
			begin
				evHit[SRC_MON_DEC] = 1'b1;
			end
		end
		evInfo[SRC_MON_INC].grp = monGrp;
		evInfo[SRC_MON_INC].ch = monCh;
		evInfo[SRC_MON_DEC].grp = monGrp;
		evInfo[SRC_MON_DEC].ch = monCh;

		// Duplicate filter; a msgDone in the compare cycle is ignored
		case (s.flt)
			IDE_FLT_IDLE:
			begin
				if (msgDone)
				begin
					if (s.ss7Mode)
					begin
						memRdEn = 1'b1;
						n.fltKey = {msgGrp, msgCh};
						n.fltSig = msgSig;
						n.flt = IDE_FLT_CMP;
					end
					else
					begin
						n.msgKeep = 1'b1;
					end
				end
			end
			IDE_FLT_CMP:
			begin
				dup = s.sigValid[s.fltKey] && (memRdData == s.fltSig);
				if (dup)
				begin
					n.msgDrop = 1'b1;
					evHit[SRC_DUP_FILT] = 1'b1;
					evInfo[SRC_DUP_FILT].grp = s.fltKey[7:5];
					evInfo[SRC_DUP_FILT].ch = s.fltKey[4:0];
				end
				else
				begin
					n.msgKeep = 1'b1;
				end
				memWrEn = 1'b1;
				n.sigValid[s.fltKey] = 1'b1;
				n.flt = IDE_FLT_IDLE;
			end
			default:
			begin
				n.flt = IDE_FLT_IDLE;
			end
		endcase

		if (bufErr)
		begin
			evHit[SRC_BUF_ERR] = 1'b1;
			evInfo[SRC_BUF_ERR].dir = bufErrDir;
			evInfo[SRC_BUF_ERR].grp = bufErrGrp;
			evInfo[SRC_BUF_ERR].ch = bufErrCh;
		end

		// Output stage: lowest slot first, one slot per descriptor
		if (!s.descValid || descReady)
		begin
			n.descValid = 1'b0;
			for (int i = 0; i < NUM_SRC; i++)
			begin
				if (s.slots[i].pend && !taken)
				begin
					taken = 1'b1;
					n.descValid = 1'b1;
					n.descWord = buildDesc(s.slots[i], i);
					n.slots[i].pend = 1'b0;
				end
			end
		end

		// A new event may refill a slot emptied this cycle; else it is lost
		for (int i = 0; i < NUM_SRC; i++)
		begin
			if (evHit[i] && !s.evMask[i])
			begin
				if (n.slots[i].pend)
				begin
					lost = 1'b1;
				end
				else
				begin
					n.slots[i] = evInfo[i];
					n.slots[i].pend = 1'b1;
				end
			end
		end

		// Register writes
		if (regWr)
		begin
			case (regAddr)
				REG_CTRL:   n.ss7Mode = regWdata[CTRL_SS7_BIT];
				REG_EVMASK: n.evMask = regWdata[NUM_SRC-1:0];
				REG_STATUS: w1c = regWdata[7:0];
				REG_IRQEN:  n.irqEn = regWdata[7:0];
				default:    n.rdData = '0;
			endcase
		end
		// Set wins over a simultaneous write-one-to-clear
		n.status = (s.status & ~w1c) | {lost, evHit};

		// Register reads, unmapped addresses read zero
		if (regRd)
		begin
			case (regAddr)
				REG_CTRL:   n.rdData[CTRL_SS7_BIT] = s.ss7Mode;
				REG_EVMASK: n.rdData[NUM_SRC-1:0] = s.evMask;
				REG_STATUS: n.rdData[7:0] = s.status;
				REG_IRQEN:  n.rdData[7:0] = s.irqEn;
				REG_STATE:
				begin
					n.rdData[STATE_OOF_BIT] = s.oofSync[1];
					n.rdData[STATE_FLT_BIT] = (s.flt == IDE_FLT_CMP);
					for (int i = 0; i < NUM_SRC; i++)
					begin
						n.rdData[STATE_PEND_LSB + i] = s.slots[i].pend;
					end
					n.rdData[STATE_CNT_LSB +: CNT_W] = s.monPrev;
				end
				default:    n.rdData = '0;
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			s <= '0;
			s.flt <= IDE_FLT_IDLE;
			s.ss7Mode <= CTRL_RESET;
			s.evMask <= EVMASK_RESET;
			s.irqEn <= IRQEN_RESET;
		end
		else
		begin
			s <= n;
		end
	end

	ide_sig_mem
	#(
		.WIDTH (SIG_W),
		.DEPTH (256)
	)
	u_sig_mem
	(
		.core_clk (core_clk),
		.reset    (reset),
		.rdEn     (memRdEn),
		.rdAddr   (memRdAddr),
		.rdData   (memRdData),
		.wrEn     (memWrEn),
		.wrAddr   (s.fltKey),
		.wrData   (s.fltSig)
	);

	assign msgKeep   = s.msgKeep;
	assign msgDrop   = s.msgDrop;
	assign descValid = s.descValid;
	assign descWord  = s.descWord;
	assign regRdata  = s.rdData;
	assign irq       = |(s.status & s.irqEn);

endmodule
`default_nettype wire

// ==== ide_pkg.sv ====
// Constants of the interrupt descriptor encoder: descriptor layout, codes, register map.
// Assumes a 32-bit descriptor word and a byte-addressed register port.
package ide_pkg;

	// Descriptor field positions
	localparam int DESC_DIR_BIT    = 31;
	localparam int DESC_GRP_LO_MSB = 30;
	localparam int DESC_GRP_LO_LSB = 29;
	localparam int DESC_CH_MSB     = 28;
	localparam int DESC_CH_LSB     = 24;
	localparam int DESC_EV_MSB     = 23;
	localparam int DESC_EV_LSB     = 20;
	localparam int DESC_ERR_MSB    = 19;
	localparam int DESC_ERR_LSB    = 16;
	localparam int DESC_GRP_HI_BIT = 14;

	// Event and error codes
	localparam logic [3:0] EV_NONE       = 4'h0;
	localparam logic [3:0] EV_PAD_ABORT  = 4'h5;
	localparam logic [3:0] EV_PAD_IDLE   = 4'h6;
	localparam logic [3:0] EV_FRAME_REC  = 4'h7;
	localparam logic [3:0] EV_MON_INC    = 4'h8;
	localparam logic [3:0] EV_MON_DEC    = 4'h9;
	localparam logic [3:0] EV_DUP_FILT   = 4'ha;
	localparam logic [3:0] ERR_NONE      = 4'h0;
	localparam logic [3:0] ERR_BUFFER    = 4'h1;

	localparam logic       DIR_RX        = 1'b0;

	// Pad-fill octets
	localparam logic [7:0] PAD_IDLE_OCT  = 8'h7e;
	localparam logic [7:0] PAD_ABORT_OCT = 8'hff;

	// Event sources, one pending slot each
	localparam int NUM_SRC       = 7;
	localparam int SRC_PAD_ABORT = 0;
	localparam int SRC_PAD_IDLE  = 1;
	localparam int SRC_FRAME_REC = 2;
	localparam int SRC_MON_INC   = 3;
	localparam int SRC_MON_DEC   = 4;
	localparam int SRC_DUP_FILT  = 5;
	localparam int SRC_BUF_ERR   = 6;
	localparam int STAT_LOST_BIT = 7;

	// Register map (byte addresses)
	localparam int               REG_ADDR_W  = 8;
	localparam logic [7:0]       REG_CTRL    = 8'h00;
	localparam logic [7:0]       REG_EVMASK  = 8'h04;
	localparam logic [7:0]       REG_STATUS  = 8'h08;
	localparam logic [7:0]       REG_IRQEN   = 8'h0c;
	localparam logic [7:0]       REG_STATE   = 8'h10;
	localparam int               CTRL_SS7_BIT = 0;
	localparam logic             CTRL_RESET   = 1'b0;
	localparam logic [6:0]       EVMASK_RESET = 7'h00;
	localparam logic [7:0]       IRQEN_RESET  = 8'h00;
	localparam int               STATE_OOF_BIT  = 0;
	localparam int               STATE_FLT_BIT  = 1;
	localparam int               STATE_PEND_LSB = 8;
	localparam int               STATE_CNT_LSB  = 16;

endpackage

// ==== ide_sig_mem.sv ====
// Small memory holding the signature of the last message per channel.
// Assumes one clock; read data is registered and valid the cycle after rdEn.
`timescale 1ns/1ps
`default_nettype none
module ide_sig_mem
#(
	parameter int WIDTH = 32,
	parameter int DEPTH = 256
)
(
	input  wire logic                     core_clk,
	input  wire logic                     reset,
	input  wire logic                     rdEn,
	input  wire logic [$clog2(DEPTH)-1:0] rdAddr,
	output logic      [WIDTH-1:0]         rdData,
	input  wire logic                     wrEn,
	input  wire logic [$clog2(DEPTH)-1:0] wrAddr,
	input  wire logic [WIDTH-1:0]         wrData
);

	logic [WIDTH-1:0] mem [DEPTH];

	// Array stays without reset; validity is tracked by the caller
	always_ff @(posedge core_clk)
	begin
		if (wrEn)
		begin
			mem[wrAddr] <= wrData;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			rdData <= '0;
		end
		else if (rdEn)
		begin
			rdData <= mem[rdAddr];
		end
	end

endmodule
`default_nettype wire

// ==== ide_encoder_chk.sv ====
// Concurrent checks on the descriptor, filter and register ports of the encoder.
// Assumes the single core_clk domain and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module ide_encoder_chk
	import ide_pkg::*;
(
	input wire logic        core_clk,
	input wire logic        reset,
	input wire logic        descValid,
	input wire logic [31:0] descWord,
	input wire logic        descReady,
	input wire logic        msgDone,
	input wire logic        msgKeep,
	input wire logic        msgDrop,
	input wire logic        regRd,
	input wire logic [31:0] regRdata
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	// Answer lands one cycle later without compare, two with it
	sequence s_answer;
		##[1:2] (msgKeep || msgDrop);
	endsequence
	a_legal_code: assert property (descValid |-> descWord[23:20] <= 4'ha)
		else $error("reserved event code posted");
	a_one_code: assert property (descValid |-> ((descWord[23:20] == 4'h0) != (descWord[19:16] == 4'h0)))
		else $error("descriptor event and error both set or both clear");
	a_error_code: assert property (descValid && descWord[19:16] != 4'h0 |-> descWord[19:16] == ERR_BUFFER)
		else $error("unexpected error code");
	a_event_rx: assert property (descValid && descWord[23:20] != 4'h0 |-> descWord[31] == DIR_RX)
		else $error("event posted with transmit direction");
	a_spare_bits: assert property (descValid |-> descWord[15] == 1'b0 && descWord[13:0] == 14'h0)
		else $error("descriptor spare bits not zero");
	a_desc_hold: assert property (descValid && !descReady |=> descValid && $stable(descWord))
		else $error("descriptor withdrawn before taken");
	a_keep_drop: assert property (msgDrop |-> !msgKeep)
		else $error("message both kept and dropped");
	a_filter_answer: assert property (msgDone |-> s_answer)
		else $error("no filter answer in time");
	a_rdata_idle: assert property (!regRd |=> regRdata == 32'h0)
		else $error("read data outside read slot");
endmodule
bind ide_encoder ide_encoder_chk i_chk (
	.core_clk(core_clk), .reset(reset), .descValid(descValid), .descWord(descWord),
	.descReady(descReady), .msgDone(msgDone), .msgKeep(msgKeep), .msgDrop(msgDrop),
	.regRd(regRd), .regRdata(regRdata)
);
`default_nettype wire

// ==== ide_host_model.sv ====
// Host side taking descriptors; records the last word taken and a count.
// Assumes stall is driven by the bench; a stalled host leaves descReady low.
`timescale 1ns/1ps
`default_nettype none
module ide_host_model
(
	input  wire logic        core_clk,
	input  wire logic        reset,
	input  wire logic        descValid,
	input  wire logic [31:0] descWord,
	input  wire logic        stall,
	output logic             descReady,
	output logic      [31:0] gotWord,
	output logic      [7:0]  gotCnt
);
	assign descReady = !stall;
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			gotWord <= 32'h0;
			gotCnt  <= 8'h00;
		end
		else if (descValid && descReady)
		begin
			gotWord <= descWord;
			gotCnt  <= gotCnt + 8'h01;
		end
	end
endmodule
`default_nettype wire

// ==== interrupt_descriptor_encoder_tb.sv ====
// Bench for the descriptor encoder: events in, descriptors and registers out.
// Assumes the host model takes descriptors and that no parameter is shortened.
`timescale 1ns/1ps
`default_nettype none
module interrupt_descriptor_encoder_tb;
	import ide_pkg::*;
	logic core_clk, reset, padValid, oofPin, msgDone, bufErr, bufErrDir, regWr, regRd, stall;
	logic [2:0] padGrp, portGrp, monGrp, msgGrp, bufErrGrp;
	logic [4:0] padCh, monCh, msgCh, bufErrCh;
	logic [7:0] padOctet, monCount, regAddr, gotCnt, n0;
	logic [31:0] msgSig, regWdata, regRdata, descWord, gotWord, rv;
	logic [7:0] expCnt = 8'h00;
	logic msgKeep, msgDrop, descValid, descReady, irq;
	int fail_count = 0;
	int check_count = 0;
	ide_encoder i_dut (.core_clk(core_clk), .reset(reset), .padValid(padValid), .padGrp(padGrp),
		.padCh(padCh), .padOctet(padOctet), .oofPin(oofPin), .portGrp(portGrp),
		.monCount(monCount), .monGrp(monGrp), .monCh(monCh), .msgDone(msgDone),
		.msgGrp(msgGrp), .msgCh(msgCh), .msgSig(msgSig), .msgKeep(msgKeep), .msgDrop(msgDrop),
		.bufErr(bufErr), .bufErrDir(bufErrDir), .bufErrGrp(bufErrGrp), .bufErrCh(bufErrCh),
		.descValid(descValid), .descWord(descWord), .descReady(descReady), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq));
	ide_host_model i_host (.core_clk(core_clk), .reset(reset), .descValid(descValid),
		.descWord(descWord), .stall(stall), .descReady(descReady), .gotWord(gotWord),
		.gotCnt(gotCnt));
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	function automatic logic [31:0] mk(logic d, logic [2:0] g, logic [4:0] c, logic [3:0] e,
		logic [3:0] r);
		mk = {d, g[1:0], c, e, r, 1'b0, g[2], 14'h0};
	endfunction
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge core_clk);
		regWr <= 1'b1; regAddr <= a; regWdata <= d;
		@(posedge core_clk);
		regWr <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk);
		regRd <= 1'b1; regAddr <= a;
		@(posedge core_clk);
		regRd <= 1'b0;
		#1 d = regRdata;
	endtask
	// Counts owed descriptors so back-to-back takes are each seen; samples on the falling edge
	task automatic desc(string what, logic [31:0] exp);
		expCnt = expCnt + 8'h01;
		for (int i = 0; i < 20 && gotCnt !== expCnt; i++) @(negedge core_clk);
		check(what, gotWord, exp);
	endtask
	task automatic pad(logic [7:0] o);
		@(posedge core_clk);
		padValid <= 1'b1; padOctet <= o; padGrp <= 3'h5; padCh <= 5'h03;
		@(posedge core_clk);
		padValid <= 1'b0;
	endtask
	task automatic t_pad;
		pad(8'h55);
		pad(8'hff);
		desc("abort", mk(1'b0, 3'h5, 5'h03, EV_PAD_ABORT, ERR_NONE));
		pad(8'hff);
		pad(8'h7e);
		desc("idle", mk(1'b0, 3'h5, 5'h03, EV_PAD_IDLE, ERR_NONE));
		$display("test pad done");
	endtask
	task automatic t_frame;
		@(posedge core_clk);
		oofPin <= 1'b1;
		repeat (6) @(posedge core_clk);
		oofPin <= 1'b0;
		desc("frame", mk(1'b0, 3'h6, 5'h00, EV_FRAME_REC, ERR_NONE));
		$display("test frame done");
	endtask
	task automatic t_mon;
		wr(REG_CTRL, 32'h1);
		monCount <= 8'h01;
		desc("inc", mk(1'b0, 3'h2, 5'h1f, EV_MON_INC, ERR_NONE));
		@(posedge core_clk);
		monCount <= 8'h00;
		desc("dec", mk(1'b0, 3'h2, 5'h1f, EV_MON_DEC, ERR_NONE));
		$display("test monitor done");
	endtask
	task automatic t_dup;
		for (int k = 0; k < 2; k++)
		begin
			@(posedge core_clk);
			msgDone <= 1'b1;
			@(posedge core_clk);
			msgDone <= 1'b0;
			@(posedge core_clk);
			#1 check("keep", msgKeep, k == 0);
			check("drop", msgDrop, k == 1);
		end
		desc("filter", mk(1'b0, 3'h0, 5'h02, EV_DUP_FILT, ERR_NONE));
		// Outside signalling mode a repeat is kept and monitor steps stay silent
		wr(REG_CTRL, 32'h0);
		msgDone <= 1'b1;
		monCount <= 8'h05;
		@(posedge core_clk);
		msgDone <= 1'b0;
		#1 check("keep plain", msgKeep, 1'b1);
		check("drop plain", msgDrop, 1'b0);
		repeat (4) @(posedge core_clk);
		check("no monitor", gotCnt, expCnt);
		$display("test filter done");
	endtask
	// Stalled host: pad abort holds the output while the buffer error waits in its slot
	task automatic t_stall;
		stall <= 1'b1;
		pad(8'hff);
		@(posedge core_clk);
		bufErr <= 1'b1; bufErrDir <= 1'b1; bufErrGrp <= 3'h3; bufErrCh <= 5'h11;
		@(posedge core_clk);
		bufErr <= 1'b0;
		repeat (5) @(posedge core_clk);
		stall <= 1'b0;
		desc("first", mk(1'b0, 3'h5, 5'h03, EV_PAD_ABORT, ERR_NONE));
		desc("buffer", mk(1'b1, 3'h3, 5'h11, EV_NONE, ERR_BUFFER));
		$display("test stall done");
	endtask
	task automatic t_irq;
		wr(REG_STATUS, 32'hff);
		wr(REG_EVMASK, 32'h40);
		wr(REG_IRQEN, 32'h40);
		n0 = gotCnt;
		@(posedge core_clk);
		bufErr <= 1'b1;
		@(posedge core_clk);
		bufErr <= 1'b0;
		repeat (4) @(posedge core_clk);
		check("masked", gotCnt, n0);
		rd(REG_STATUS, rv);
		check("status", rv, 32'h40);
		check("irq", irq, 1'b1);
		wr(REG_STATUS, 32'h40);
		#1 check("irq clear", irq, 1'b0);
		rd(8'hfc, rv);
		check("unmapped", rv, 32'h0);
		$display("test irq done");
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		#100000;
		fail_count++;
		wrap_up;
	end
	initial
	begin
		{reset, padValid, oofPin, msgDone, bufErr, bufErrDir, regWr, regRd, stall} = 9'h100;
		{padGrp, padCh, padOctet, bufErrGrp, bufErrCh, regAddr, regWdata} = '0;
		{portGrp, monGrp, monCh, msgGrp, msgCh, monCount} = {3'h6, 3'h2, 5'h1f, 3'h0, 5'h02, 8'h0};
		msgSig = 32'hc3a5_0f96;
		repeat (16) @(posedge core_clk);
		reset <= 1'b0;
		repeat (3) @(posedge core_clk);
		t_pad;
		t_frame;
		t_mon;
		t_dup;
		t_stall;
		t_irq;
		wrap_up;
	end
endmodule
`default_nettype wire
